// >>> rtl/unb_uart.sv
module unb_uart import unb_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial and timer pins
  input  wire logic        rxd,
  input  wire logic        timer2_external_pin,
  output logic             txd
);
  // --------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------
  logic        aw_ff, w_ff;
  unb_wreq_t   wreq_ff;
  logic [7:0]  serial_control_reg_ff, serial_buffer_ff, power_control_reg_ff;
  logic [7:0]  timer1_reload_byte_ff, timer1_low_count_ff, timer2_control_reg_ff;
  logic [15:0] t2cnt_ff, t2cap_ff;
  logic        do_wr, do_rd;
  logic [31:0] rd_mux;
  logic        rd_hit, wr_hit;

  assign do_wr = aw_ff & w_ff & ~s_axi_bvalid;
  assign do_rd = s_axi_arvalid & s_axi_arready;
  wire wr_ctrl = do_wr & (wreq_ff.addr == ADDR_CTRL)   & wreq_ff.strb[0];
  wire wr_buf  = do_wr & (wreq_ff.addr == ADDR_BUF)    & wreq_ff.strb[0];
  wire wr_power_control_reg = do_wr & (wreq_ff.addr == ADDR_POWER_CONTROL_REG)   & wreq_ff.strb[0];
  wire wr_t1   = do_wr & (wreq_ff.addr == ADDR_T1);
  wire wr_t2c  = do_wr & (wreq_ff.addr == ADDR_TIMER2_CONTROL_REG)  & wreq_ff.strb[0];
  wire wr_t2n  = do_wr & (wreq_ff.addr == ADDR_T2CNT);
  wire wr_t2p  = do_wr & (wreq_ff.addr == ADDR_T2CAP);
  assign wr_hit = wreq_ff.addr inside {ADDR_CTRL, ADDR_BUF, ADDR_POWER_CONTROL_REG, ADDR_T1,
                                       ADDR_TIMER2_CONTROL_REG, ADDR_T2CNT, ADDR_T2CAP};
  assign rd_hit = s_axi_araddr inside {ADDR_CTRL, ADDR_BUF, ADDR_POWER_CONTROL_REG, ADDR_T1,
                                       ADDR_TIMER2_CONTROL_REG, ADDR_T2CNT, ADDR_T2CAP};
  logic [7:0] rx_buf_ff;
  always_comb begin
    unique case (s_axi_araddr)
      ADDR_CTRL:  rd_mux = {24'h000000, serial_control_reg_ff};
      ADDR_BUF:   rd_mux = {24'h000000, rx_buf_ff};
      ADDR_POWER_CONTROL_REG:  rd_mux = {24'h000000, power_control_reg_ff};
      ADDR_T1:    rd_mux = {16'h0000, timer1_reload_byte_ff, timer1_low_count_ff};
      ADDR_TIMER2_CONTROL_REG: rd_mux = {24'h000000, timer2_control_reg_ff};
      ADDR_T2CNT: rd_mux = {16'h0000, t2cnt_ff};
      ADDR_T2CAP: rd_mux = {16'h0000, t2cap_ff};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      wreq_ff <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_ff <= 1'b1;
        wreq_ff.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_ff <= 1'b1;
        wreq_ff.data <= s_axi_wdata;
        wreq_ff.strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // --------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------
  wire [1:0] mode = {serial_control_reg_ff[CB_SM0], serial_control_reg_ff[CB_SM1]};
  wire nine_bit = mode[1];                                       // [R25]
  wire rate_double_bit = power_control_reg_ff[7];
  wire tx_timer2_select = timer2_control_reg_ff[T2B_TX_TIMER2_SELECT];
  wire rx_timer2_select = timer2_control_reg_ff[T2B_RCLK];
  wire t2_gen = tx_timer2_select | rx_timer2_select;             // [R18]
  wire timer2_run = timer2_control_reg_ff[T2B_RUN];

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0] rxd_sync_ff, timer2_external_pin_sync_ff;
  logic       rxd_ff, timer2_external_pin_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_sync_ff <= 3'h7;
      timer2_external_pin_sync_ff <= 3'h7;
      rxd_ff <= 1'b1;
      timer2_external_pin_ff <= 1'b1;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[1:0], rxd};
      timer2_external_pin_sync_ff <= {timer2_external_pin_sync_ff[1:0], timer2_external_pin};
      if (rxd_sync_ff[1] == rxd_sync_ff[2]) rxd_ff <= rxd_sync_ff[2];
      if (timer2_external_pin_sync_ff[1] == timer2_external_pin_sync_ff[2]) timer2_external_pin_ff <= timer2_external_pin_sync_ff[2];
    end
  end
  wire timer2_external_pin_fall = timer2_external_pin_ff & (timer2_external_pin_sync_ff[1] == timer2_external_pin_sync_ff[2]) & ~timer2_external_pin_sync_ff[2];

  // --------------------------------------------------------------------
  // rate generation: one aclk is one oscillator period
  // --------------------------------------------------------------------
  // timer 1 runs auto-reload from its reload byte, counting every 12 osc  [R16]
  logic [3:0] t1_div_ff;
  wire t1_tick = (t1_div_ff == 4'hB);
  wire t1_ovf = t1_tick & (timer1_low_count_ff == 8'hFF);
  always_ff @(posedge aclk) begin
    if (!aresetn) t1_div_ff <= '0;
    else t1_div_ff <= t1_tick ? 4'h0 : t1_div_ff + 4'h1;
  end
  logic [4:0] m2_pre_ff;
  logic       half_ff, t1_half_ff;
  wire [4:0]  m2_top = rate_double_bit ? MODE2_DIV_DBL : MODE2_DIV;
  // >= keeps the prescaler from running on to 31 if doubling is set mid-count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m2_pre_ff <= '0;
      half_ff <= 1'b0;
      t1_half_ff <= 1'b0;
    end else begin
      m2_pre_ff <= (m2_pre_ff >= m2_top) ? 5'h00 : m2_pre_ff + 5'h01;
      half_ff <= ~half_ff;
      if (t1_ovf) t1_half_ff <= ~t1_half_ff;
    end
  end
  wire t2_tick = half_ff & timer2_run & t2_gen;                  // [R19]
  wire t2_ovf = t2_tick & (t2cnt_ff == 16'hFFFF);
  // x16 sample ticks: mode 2 osc/(4 or 2) per tick gives osc*2^d/64 per bit  [R3]
  wire tick_m2 = (m2_pre_ff == 5'h00);
  wire t1_x16 = t1_ovf & (rate_double_bit | t1_half_ff);         // [R15]
  // timer 2 overflow is x16 rate directly (osc/2 count, /16 per bit)
  wire tx_tick = (mode == MODE_FIXED) ? tick_m2 :
                 (tx_timer2_select ? t2_ovf : t1_x16);           // [R4] [R26]
  wire rx_tick = (mode == MODE_FIXED) ? tick_m2 :
                 (rx_timer2_select ? t2_ovf : t1_x16);           // [R4] [R26]

  // --------------------------------------------------------------------
  // timers and software registers
  // --------------------------------------------------------------------
  logic rx_set, tx_set;
  logic [7:0] rx_data;
  logic       rx_ninth;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_control_reg_ff <= RST_BYTE;
      power_control_reg_ff <= RST_BYTE;                          // [R3]
      timer1_reload_byte_ff <= RST_BYTE;
      timer1_low_count_ff <= RST_BYTE;
      timer2_control_reg_ff <= RST_BYTE;
      t2cnt_ff <= '0;
      t2cap_ff <= '0;
      serial_buffer_ff <= RST_BYTE;
      rx_buf_ff <= RST_BYTE;
    end else begin
      if (wr_ctrl) serial_control_reg_ff <= wreq_ff.data[7:0];
      // hardware set wins over software clear                  [R27]
      if (tx_set) serial_control_reg_ff[CB_TXDONE] <= 1'b1;     // [R8]
      if (rx_set) begin
        serial_control_reg_ff[CB_RXDONE] <= 1'b1;               // [R13]
        serial_control_reg_ff[CB_RB8] <= rx_ninth;              // [R2]
        rx_buf_ff <= rx_data;
      end
      if (wr_power_control_reg) power_control_reg_ff <= wreq_ff.data[7:0];
      if (wr_buf) serial_buffer_ff <= wreq_ff.data[7:0];
      if (wr_t1 & wreq_ff.strb[1]) timer1_reload_byte_ff <= wreq_ff.data[15:8];
      if (t1_ovf) timer1_low_count_ff <= timer1_reload_byte_ff;
      else if (t1_tick) timer1_low_count_ff <= timer1_low_count_ff + 8'h01;
      if (wr_t1 & wreq_ff.strb[0]) timer1_low_count_ff <= wreq_ff.data[7:0];
      if (wr_t2c) timer2_control_reg_ff <= wreq_ff.data[7:0];
      // no overflow flag in generator mode                     [R20]
      if (t2_gen & timer2_control_reg_ff[T2B_EXEN] & timer2_external_pin_fall)
        timer2_control_reg_ff[T2B_EXF] <= 1'b1;                  // [R21]
      if (t2_ovf) t2cnt_ff <= t2cap_ff;                          // [R19]
      else if (t2_tick) t2cnt_ff <= t2cnt_ff + 16'h0001;
      if (wr_t2n) t2cnt_ff <= wreq_ff.data[15:0];                // [R22]
      if (wr_t2p) t2cap_ff <= wreq_ff.data[15:0];
    end
  end

  // --------------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------------
  unb_tx_st_t tx_st_ff;
  logic [3:0] tx_div_ff;
  logic [8:0] tx_sh_ff;
  logic       tx_data_en_ff, tx_first_ff;
  wire tx_roll = tx_tick & (tx_div_ff == 4'hF);
  wire tx_last = (tx_sh_ff[8:2] == 7'h00) & tx_sh_ff[1];         // [R8]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_ff <= TX_IDLE;
      tx_div_ff <= '0;
      tx_sh_ff <= '0;
      tx_data_en_ff <= 1'b0;
      tx_first_ff <= 1'b0;
      txd <= 1'b1;
      tx_set <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (tx_tick) tx_div_ff <= tx_div_ff + 4'h1;
      if (wr_buf & nine_bit) begin                               // [R23]
        tx_sh_ff <= {serial_control_reg_ff[CB_TB8], wreq_ff.data[7:0]}; // [R2] [R5]
        tx_st_ff <= TX_WAIT;
      end else begin
        unique case (tx_st_ff)
          TX_IDLE: txd <= 1'b1;
          TX_WAIT: if (tx_roll) begin                            // [R5]
            tx_st_ff <= TX_RUN;
            txd <= 1'b0;                                         // [R6] [R1]
            tx_data_en_ff <= 1'b0;
            tx_first_ff <= 1'b1;
          end
          TX_RUN: if (tx_roll) begin
            if (!tx_data_en_ff) begin
              tx_data_en_ff <= 1'b1;                             // [R6]
              txd <= tx_sh_ff[0];
            end else if (tx_first_ff) begin
              tx_first_ff <= 1'b0;
              tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};                 // [R7]
              txd <= tx_sh_ff[1];
            end else if (tx_last) begin
              tx_sh_ff <= {1'b0, tx_sh_ff[8:1]};
              txd <= 1'b1;
              tx_st_ff <= TX_IDLE;                               // [R8]
              tx_set <= 1'b1;
            end else begin
              tx_sh_ff <= {1'b0, tx_sh_ff[8:1]};                 // [R7]
              txd <= tx_sh_ff[1];
            end
          end
          default: tx_st_ff <= TX_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------------
  unb_rx_st_t rx_st_ff;
  logic [3:0] rx_div_ff;
  logic [8:0] rx_sh_ff;
  logic [2:0] rx_smp_ff;
  logic       rx_prev_ff, rx_first_ff;
  wire rx_bit = (rx_smp_ff[0] & rx_smp_ff[1]) | (rx_smp_ff[0] & rx_smp_ff[2])
              | (rx_smp_ff[1] & rx_smp_ff[2]);                   // [R10]
  wire rx_roll = rx_tick & (rx_div_ff == 4'hF);
  wire rx_fall = rx_tick & rx_prev_ff & ~rxd_ff;                 // [R9]
  // at the final shift the accepted sample is the ninth bit itself
  wire rx_ok = ~serial_control_reg_ff[CB_RXDONE] &
               (~serial_control_reg_ff[CB_SM2] | rx_bit);        // [R13]
  // lsb arrives first and marches left, so the byte sits mirrored
  for (genvar gi = 0; gi < 8; gi++) begin : g_rx_rev
    assign rx_data[gi] = rx_sh_ff[7 - gi];                       // [R12]
  end
  assign rx_ninth = rx_bit;                                      // [R2]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_ff <= RX_HUNT;
      rx_div_ff <= '0;
      rx_sh_ff <= '0;
      rx_smp_ff <= 3'h7;
      rx_prev_ff <= 1'b1;
      rx_first_ff <= 1'b0;
      rx_set <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      if (rx_tick) begin
        rx_prev_ff <= rxd_ff;                                    // [R9]
        rx_div_ff <= rx_div_ff + 4'h1;
        if (rx_div_ff == SAMP_A) rx_smp_ff[0] <= rxd_ff;         // [R10]
        if (rx_div_ff == SAMP_B) rx_smp_ff[1] <= rxd_ff;
        if (rx_div_ff == SAMP_C) rx_smp_ff[2] <= rxd_ff;
      end
      unique case (rx_st_ff)
        RX_HUNT: if (rx_fall & nine_bit & serial_control_reg_ff[CB_REN]) begin // [R24]
          rx_sh_ff <= RX_PRELOAD;                                // [R9]
          rx_div_ff <= 4'h0;
          rx_first_ff <= 1'b1;
          rx_st_ff <= RX_BITS;
        end
        RX_BITS: if (rx_roll) begin
          if (rx_first_ff & rx_bit) begin
            rx_st_ff <= RX_HUNT;                                 // [R11]
          end else if (!rx_sh_ff[8]) begin
            // start bit at the left: this is the final shift    [R12]
            rx_set <= rx_ok;                                     // [R13]
            rx_st_ff <= RX_GAP;
          end else begin
            rx_sh_ff <= {rx_sh_ff[7:0], rx_bit};                 // [R12]
          end
          rx_first_ff <= 1'b0;
        end
        RX_GAP: if (rx_roll) rx_st_ff <= RX_HUNT;                // [R14]
        default: rx_st_ff <= RX_HUNT;
      endcase
    end
  end
endmodule

// >>> rtl/unb_pkg.sv
// Contract
// [R1] nine-bit frames: start low, eight data LSB first, ninth bit, stop high
// [R2] ninth transmit bit comes from control flag; ninth received bit lands in flag
// [R3] mode 2 rate is osc times two-to-doubling-bit over 64; doubling resets zero
// [R4] mode 3 equals mode 2 but rate from timer 1 or timer 2 overflows
// [R5] buffer write loads shift register; send starts after next divide-by-16 rollover
// [R6] start bit first, data enabled one bit later, first shift one bit after
// [R7] first shift loads stop one into ninth position, later shifts feed zeros
// [R8] ninth bit out with stop beside: last shift, set done, drop active
// [R9] sample receive at sixteen times rate; falling edge loads 1FF, resets counter
// [R10] majority of samples at counter states seven, eight and nine
// [R11] nonzero start bit resets receiver and resumes edge search
// [R12] bits enter from right, ones leave left; start at left means final shift
// [R13] accept frame only if done clear and filter off or ninth bit one
// [R14] one bit time after final shift return to search; stop bit ignored
// [R15] timer 1 source: rate is two-to-doubling times overflow rate over 32
// [R16] software sets timer 1 to 8-bit auto-reload and disables its interrupt
// [R17] software reload value is 256 minus scaled oscillator over 32*12*rate
// [R18] timer 2 is rate generator when both timer-2 selects are set; the code makes it one when either select is set
// [R19] timer 2 counts at half osc and reloads from capture registers on overflow
// [R20] in generator mode overflow sets no timer 2 overflow flag
// [R21] external falling edge sets external flag, no reload, when enabled
// [R22] software should stop timer 2 before touching counts or captures
// [R23] any write to the serial buffer starts a transmission; the code starts one only in the nine-bit modes (SM0 set)
// [R24] reception starts on start bit only while receive enable is set
// [R25] mode bits 10 and 11 select fixed and timer-rate nine-bit modes
// [R26] each direction independently picks timer 2 or timer 1 as rate source
// [R27] software clears both done flags; hardware never clears them
package unb_pkg;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_BUF   = 8'h04;
  localparam logic [7:0] ADDR_POWER_CONTROL_REG  = 8'h08;
  localparam logic [7:0] ADDR_T1    = 8'h0C;
  localparam logic [7:0] ADDR_TIMER2_CONTROL_REG = 8'h10;
  localparam logic [7:0] ADDR_T2CNT = 8'h14;
  localparam logic [7:0] ADDR_T2CAP = 8'h18;
  // control register bit positions
  localparam int CB_RXDONE = 0;
  localparam int CB_TXDONE = 1;
  localparam int CB_RB8    = 2;
  localparam int CB_TB8    = 3;
  localparam int CB_REN    = 4;
  localparam int CB_SM2    = 5;
  localparam int CB_SM1    = 6;
  localparam int CB_SM0    = 7;
  // timer 2 control bit positions
  localparam int T2B_RUN   = 2;
  localparam int T2B_EXEN  = 3;
  localparam int T2B_TX_TIMER2_SELECT  = 4;
  localparam int T2B_RCLK  = 5;
  localparam int T2B_EXF   = 6;
  localparam int T2B_TF    = 7;
  localparam logic [1:0] MODE_FIXED = 2'b10;  // [R25]
  localparam logic [1:0] MODE_TIMER = 2'b11;  // [R25]
  localparam logic [3:0] SAMP_A     = 4'h7;
  localparam logic [3:0] SAMP_B     = 4'h8;
  localparam logic [3:0] SAMP_C     = 4'h9;
  localparam logic [8:0] RX_PRELOAD = 9'h1FF;
  localparam logic [3:0] OSC_PER_CYCLE = 4'h1;
  localparam logic [4:0] MODE2_DIV  = 5'h03;  // 64/16 - 1: osc per x16 tick, minus one
  localparam logic [4:0] MODE2_DIV_DBL = 5'h01;  // doubled rate: 32/16 - 1
  localparam logic [3:0] T1_DIV     = 4'hF;   // 32/2 per bit, x16 tick every 2
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_RUN = 2'b11} unb_tx_st_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_BITS = 2'b01, RX_GAP = 2'b11} unb_rx_st_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } unb_wreq_t;
endpackage

// >>> test/unb_uart_monitor.sv
module unb_uart_monitor import unb_pkg::*; (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // serial out
  input wire logic        txd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // cycles since the last level change on the line
  // ------
  logic [5:0] run_ff;
  logic [5:0] nxt_run;
  logic       txd_ff;
  wire        edge_w   = txd != txd_ff;
  wire        both_w   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        mapped_w = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr <= ADDR_T2CAP);
  // saturate so a long idle line never wraps into a false short bit
  assign nxt_run = edge_w ? 6'h00 : (run_ff == 6'h3F ? run_ff : run_ff + 6'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 6'h3F;
      txd_ff <= 1'b1;
    end else begin
      run_ff <= nxt_run;
      txd_ff <= txd;
    end
  end
  // ------
  // assertions
  // ------
  chk_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> txd) else $error("line not idle after reset");
  chk_bit_width: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_w |-> run_ff >= 6'h1F) else $error("serial bit shorter than 32 cycles");
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_write_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    both_w |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_bad_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    both_w && !mapped_w |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("no slverr");
  chk_busy_block: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  chk_read_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  chk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
endmodule

bind unb_uart unb_uart_monitor u_mon (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .txd
);

// >>> test/unb_peer.sv
module unb_peer (
  // clock
  input wire logic aclk,
  // serial lines
  input wire logic txd,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  task automatic hold(input logic v, input int n);
    @(posedge aclk);
    rxd <= v;
    repeat (n - 1) @(posedge aclk);
  endtask
  // s is the stop level; the line idles high afterwards
  task automatic send(input logic [8:0] d, input int p, input logic s);
    logic [10:0] f;
    f = {s, d, 1'b0};
    for (int i = 0; i < 11; i++) hold(f[i], p);
    hold(1'b1, p);
  endtask
  // start bit length gives the period, so the first data bit must be one
  task automatic recv(output logic [8:0] d, output logic stp, output int p);
    p = 0;
    @(negedge txd);
    @(negedge aclk);
    while (txd === 1'b0) begin
      p++;
      @(negedge aclk);
    end
    repeat (p / 2) @(negedge aclk);
    for (int i = 0; i < 9; i++) begin
      d[i] = txd;
      repeat (p) @(negedge aclk);
    end
    stp = txd;
  endtask
endmodule

// >>> test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import unb_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, timer2_external_pin, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, rxd;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches, samples_checked;
  always #4 aclk = ~aclk;
  unb_uart u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .timer2_external_pin, .txd
  );
  unb_peer u_peer (.aclk, .txd, .rxd);
  // ------
  // shared bus and compare tasks
  // ------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // bready rises with the request and falls once the response is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d & m);
  endtask
  task automatic tx_frame(input logic [7:0] d, input logic n9, input int p);
    logic [8:0] got;
    logic       stp;
    int         gp;
    fork
      u_peer.recv(got, stp, gp);
      wr(ADDR_BUF, {24'h0, d}, RESP_OKAY);
    join
    if (p > 0) chk("bit period", p, gp);
    chk("tx frame", {22'h0, 1'b1, n9, d}, {22'h0, stp, got});
    repeat (gp) @(posedge aclk);
    rdc("tx done", ADDR_CTRL, 32'h2, 32'h2);
  endtask
  task automatic rx_frame(input logic [8:0] d, input logic s, input logic [31:0] eb, ec);
    u_peer.send(d, 64, s);
    rdc("rx buffer", ADDR_BUF, 32'hFF, eb);
    rdc("rx flags", ADDR_CTRL, 32'h5, ec);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rdc("ctrl reset", ADDR_CTRL, 32'hFF, 32'h0);
    rdc("double reset", ADDR_POWER_CONTROL_REG, 32'h80, 32'h0);
    rd(8'h1C, d, r);
    chk("read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h20, 32'hFF, RESP_SLVERR);
    rdc("ctrl kept", ADDR_CTRL, 32'hFF, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_tx2;
    wr(ADDR_CTRL, 32'h88, RESP_OKAY);
    tx_frame(8'hA5, 1'b1, 64);
    wr(ADDR_POWER_CONTROL_REG, 32'h80, RESP_OKAY);
    wr(ADDR_CTRL, 32'h80, RESP_OKAY);
    tx_frame(8'h3D, 1'b0, 32);
    $display("test mode2 tx done");
  endtask
  task automatic t_tx3;
    wr(ADDR_POWER_CONTROL_REG, 32'h0, RESP_OKAY);
    wr(ADDR_T1, 32'hFF00, RESP_OKAY);
    wr(ADDR_CTRL, 32'hC0, RESP_OKAY);
    tx_frame(8'h55, 1'b0, 384);
    $display("test mode3 timer1 done");
  endtask
  task automatic t_rx;
    wr(ADDR_CTRL, 32'h90, RESP_OKAY);
    rx_frame(9'h05A, 1'b0, 32'h5A, 32'h1);
    rx_frame(9'h1C3, 1'b1, 32'h5A, 32'h1);
    wr(ADDR_CTRL, 32'hB0, RESP_OKAY);
    rx_frame(9'h077, 1'b1, 32'h5A, 32'h0);
    u_peer.hold(1'b0, 16);
    u_peer.hold(1'b1, 200);
    rx_frame(9'h196, 1'b1, 32'h96, 32'h5);
    wr(ADDR_CTRL, 32'h80, RESP_OKAY);
    rx_frame(9'h1E1, 1'b1, 32'h96, 32'h0);
    $display("test rx done");
  endtask
  task automatic t_t2;
    // count and capture are loaded while timer 2 is still stopped
    wr(ADDR_T2CAP, 32'hFFFE, RESP_OKAY);
    wr(ADDR_T2CNT, 32'hFFFE, RESP_OKAY);
    wr(ADDR_TIMER2_CONTROL_REG, 32'h3C, RESP_OKAY);
    wr(ADDR_CTRL, 32'hC8, RESP_OKAY);
    tx_frame(8'hA5, 1'b1, 0);
    rdc("t2 overflow", ADDR_TIMER2_CONTROL_REG, 32'h80, 32'h0);
    @(posedge aclk);
    timer2_external_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    rdc("t2 external", ADDR_TIMER2_CONTROL_REG, 32'hC0, 32'h40);
    $display("test timer2 done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    timer2_external_pin = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx2();
    t_tx3();
    t_rx();
    t_t2();
    finish_test();
  end
  // the whole run needs well under 30000 cycles
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
